// ---- verification/cof_can_model.sv ----
// Frame sink standing in for the CAN controller on the far side.
// Assumes the framer's frame port on clk_sys; slow makes it stall.
module cof_can_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Frame port
   input wire logic tx_valid,
   output logic tx_ready,
   // Pacing
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_ff;
   // Slow mode takes one frame in four cycles, like a busy bus
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= 2'h0;
         tx_ready <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
         tx_ready <= !slow || (cnt_ff == 2'h3);
      end
   end
endmodule : cof_can_model

// ---- verification/cof_framer_asserts.sv ----
// Checker for the frame and register ports of the framer.
// Assumes it is bound to cof_framer and sees only its ports.
module cof_framer_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Error source, frame port and network state
   input wire logic err_evt,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic [1:0] nmt_state
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Emergency identifiers span 080h..0FFh for any node
   logic is_emcy;
   assign is_emcy = tx_valid && (tx_id[10:7] == 4'h1);

   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_tx_hold: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable({tx_id, tx_dlc, tx_data}))
      else $error("frame changed before taken");
   a_emcy_len: assert property (is_emcy |-> tx_dlc == 4'h8)
      else $error("emergency length wrong");
   a_boot_frame: assert property (tx_valid && tx_id[10:7] == 4'hE
      |-> tx_dlc == 4'h1 && tx_data[7:0] == 8'h00)
      else $error("boot-up frame wrong");
   a_emcy_tail: assert property (is_emcy |-> tx_data[63:32] == 32'h0)
      else $error("emergency tail not zero");
   a_emcy_clear: assert property (is_emcy && tx_data[15:0] == 16'h0
      |-> tx_data == 64'h0) else $error("no-error frame not all zero");
   a_err_reg: assert property (is_emcy
      |-> tx_data[23:16] inside {8'h00, 8'h01, 8'h05, 8'h81})
      else $error("error register value illegal");
   a_err_sent: assert property (err_evt && nmt_state != 2'h0
      |-> ##[1:40] is_emcy) else $error("emergency not sent");
endmodule : cof_framer_asserts

bind cof_framer cof_framer_asserts cof_framer_asserts_i (.*);

// ---- verification/cof_framer_tb_top.sv ----
// Self-checking bench for the framer: boot, registers, payloads, errors.
// Assumes cof_can_model as frame sink and the bound checker.
module cof_framer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, tx_valid, tx_ready;
   logic [1:0] s_axi_bresp, s_axi_rresp, nmt_state;
   logic [31:0] s_axi_rdata;
   logic signed [15:0] incl_x = 16'h0, incl_y = 16'h0, temp_c = 16'h001A;
   logic signed [15:0] acc_raw_x = 16'hFC18, acc_raw_y = 16'h0011;
   logic signed [15:0] acc_raw_z = 16'h03E8, acc_cmp_x = 16'hD8F0;
   logic signed [15:0] acc_cmp_y = 16'h0022, acc_cmp_z = 16'h2710;
   logic sample_stb = 1'b0, err_evt = 1'b0, err_clr = 1'b0, slow = 1'b0;
   logic [15:0] err_code = 16'h0;
   logic [7:0] mfr_status = 8'h00;
   logic [10:0] tx_id;
   logic [3:0] tx_dlc;
   logic [63:0] tx_data;
   int miscompares = 0, checks = 0, cyc = 0;
   logic [15:0] codes [7] = '{16'h1000, 16'h5000, 16'h5010, 16'h5030,
      16'h6000, 16'h6200, 16'hFF20};
   logic [7:0] regs [7] = '{8'h01, 8'h05, 8'h05, 8'h05, 8'h01, 8'h01, 8'h81};
   logic [7:0] ms [3] = '{cof_pkg::MS_XTILT, cof_pkg::MS_YTILT, cof_pkg::MS_NVM};

   // Clock, cycle count, design and far-side model
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   cof_framer cof_framer_i (.*);
   cof_can_model cof_can_model_i (.*);

   task automatic chk(input string what, input logic [63:0] exp,
         input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Waits for the frame the sink takes, then compares it whole
   task automatic frame(input logic [10:0] id, input logic [3:0] dlc,
         input logic [63:0] d);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!(tx_valid && tx_ready) && n < 300);
      chk("frame taken", 64'h1, 64'(tx_valid && tx_ready));
      chk("tx_id", 64'(id), 64'(tx_id));
      chk("tx_dlc", 64'(dlc), 64'(tx_dlc));
      chk("tx_data", d, tx_data);
   endtask : frame

   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er = 2'h0);
      int n;
      @(posedge clk_sys);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      chk("bvalid", 64'h1, 64'(s_axi_bvalid));
      chk("bresp", 64'(er), 64'(s_axi_bresp));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp, input logic [1:0] er = 2'h0);
      int n;
      @(posedge clk_sys);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      chk("rvalid", 64'h1, 64'(s_axi_rvalid));
      chk("rresp", 64'(er), 64'(s_axi_rresp));
      chk("rdata", 64'(exp), 64'(s_axi_rdata & m));
   endtask : rd

   // One-cycle pulse: k 0 sample_stb, 1 err_evt, 2 err_clr
   task automatic pulse(input int k);
      @(posedge clk_sys);
      {err_clr, err_evt, sample_stb} <= 3'(1 << k);
      @(posedge clk_sys);
      {err_clr, err_evt, sample_stb} <= 3'h0;
   endtask : pulse

   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #3_000_000;
      miscompares++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      frame(11'h701, 4'h1, 64'h0);
      chk("init wait", 64'h1, 64'(cyc > 100));
      frame(11'h081, 4'h8, 64'h0);
      repeat (3) @(posedge clk_sys);
      chk("nmt_state", 64'(cof_pkg::NMT_OP), 64'(nmt_state));
      rd(cof_pkg::A_GAIN, 32'hFFFF, 32'h0100);
      rd(cof_pkg::A_NODE, 32'h7F, 32'h1);
      rd(8'h40, 32'h0, 32'h0, cof_pkg::RESP_ERR);
      wr(cof_pkg::A_STAT, 32'h0, cof_pkg::RESP_ERR);
      $display("test boot and registers done");
      incl_x <= 16'hFED4;
      pulse(0);
      frame(11'h181, 4'h2, 64'hFED4);
      wr(cof_pkg::A_CTRL, 32'h2);
      incl_x <= 16'h0BC8;
      incl_y <= 16'h0082;
      pulse(0);
      frame(11'h181, 4'h4, 64'h00820BC8);
      wr(cof_pkg::A_GAIN, 32'h0200);
      incl_x <= 16'hFF00;
      pulse(0);
      frame(11'h181, 4'h4, 64'h0104FE00);
      wr(cof_pkg::A_GAIN, 32'h0100);
      wr(cof_pkg::A_MAP1, 32'h46302);
      wr(cof_pkg::A_MAP2, 32'h10001);
      slow <= 1'b1;
      incl_x <= 16'h2382;
      pulse(0);
      frame(11'h181, 4'h8, {acc_cmp_x, acc_raw_x, 16'h2382, temp_c});
      frame(11'h281, 4'h2, {48'h0, incl_y});
      slow <= 1'b0;
      $display("test process data done");
      // Seven error-event codes in turn, each cleared before the next
      for (int i = 0; i < 7; i++) begin
         err_code <= codes[i];
         pulse(1);
         frame(11'h081, 4'h8, {40'h0, regs[i], codes[i]});
         chk("nmt_state", 64'(cof_pkg::NMT_PREOP), 64'(nmt_state));
         rd(cof_pkg::A_HIST, 32'hFFFF, {16'h0, codes[i]});
         pulse(2);
         frame(11'h081, 4'h8, 64'h0);
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         mfr_status <= ms[i];
         frame(11'h081, 4'h8, {32'h0, ms[i], 8'h81, 16'h8000});
      end
      $display("test emergency done");
      report_and_stop;
   end
endmodule : cof_framer_tb_top

// ---- verilog/cof_framer.sv ----
// Process-data and emergency frame builder with AXI4-Lite registers.
// Assumes sensor values, error events and the CAN controller's frame
// port all run on clk_sys; the bit-level CAN logic lives elsewhere.
module cof_framer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sensor values, signed
   input wire logic signed [15:0] incl_x,
   input wire logic signed [15:0] incl_y,
   input wire logic signed [15:0] temp_c,
   input wire logic signed [15:0] acc_raw_x,
   input wire logic signed [15:0] acc_raw_y,
   input wire logic signed [15:0] acc_raw_z,
   input wire logic signed [15:0] acc_cmp_x,
   input wire logic signed [15:0] acc_cmp_y,
   input wire logic signed [15:0] acc_cmp_z,
   input wire logic sample_stb,
   // Error sources
   input wire logic err_evt,
   input wire logic [15:0] err_code,
   input wire logic err_clr,
   input wire logic [7:0] mfr_status,
   // Frame output to CAN controller
   output logic tx_valid,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   input wire logic tx_ready,
   // Network state
   output logic [1:0] nmt_state
);
   logic aw_have_ff, w_have_ff, nxt_aw_have, nxt_w_have;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_do, nxt_rvalid, rd_take;
   logic [3:0] ctrl_ff;
   logic [6:0] node_ff, node_act_ff;
   logic [15:0] gain_ff;
   logic [18:0] map_ff [2];
   logic nmt_wr;
   logic [1:0] nmt_cmd;
   cof_pkg::cof_nmt_t nmt_ff;
   cof_pkg::cof_boot_t boot_ff;
   logic [7:0] init_cnt_ff;
   logic [7:0] err_reg_ff, mfr_prev_ff, hist_cnt_ff;
   logic [15:0] err_code_ff, hist_code_ff;
   logic pend_hb_ff, pend_e0_ff, pend_err_ff, pend_mfr_ff, pend_clr_ff;
   logic pend_p_ff [2];
   logic ld, tk_hb, tk_e0, tk_err, tk_mfr, tk_clr;
   logic tk_p [2];
   logic mfr_chg;
   logic [10:0] nxt_id;
   logic [3:0] nxt_dlc;
   logic [63:0] nxt_data;
   logic nxt_valid;
   logic signed [16:0] gain_s;
   logic signed [32:0] prod_x, prod_y;
   logic [15:0] srcv [9];
   logic [15:0] slot_v [2][4];
   logic [2:0] n_slot [2];
   logic [63:0] pdo_data [2];

   // Write channel: address and data are taken in either order
   always_comb begin
      wr_do = aw_have_ff & w_have_ff & ~bvalid_ff;
      nxt_aw_have = (aw_have_ff | (s_axi_awvalid & awready_ff)) & ~wr_do;
      nxt_w_have = (w_have_ff | (s_axi_wvalid & wready_ff)) & ~wr_do;
      nxt_rvalid = (rvalid_ff & ~s_axi_rready) | rd_take;
   end
   assign rd_take = s_axi_arvalid & arready_ff;

   // Channel holding flags and ready flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {aw_have_ff, w_have_ff, awready_ff, wready_ff, arready_ff} <= 5'h00;
      end else begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awready_ff <= ~nxt_aw_have;
         wready_ff <= ~nxt_w_have;
         arready_ff <= ~nxt_rvalid;
      end
   end

   // Captured write address and data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {awaddr_ff, wdata_ff, wstrb_ff} <= 44'h0;
      end else begin
         if (s_axi_awvalid && awready_ff) awaddr_ff <= s_axi_awaddr;
         if (s_axi_wvalid && wready_ff) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
      end
   end

   // Write response; unmapped or read-only offsets answer SLVERR
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {bvalid_ff, bresp_ff} <= 3'h0;
      end else if (wr_do) begin
         bvalid_ff <= 1'b1;
         case (awaddr_ff)
            cof_pkg::A_CTRL, cof_pkg::A_NODE, cof_pkg::A_GAIN,
            cof_pkg::A_MAP1, cof_pkg::A_MAP2, cof_pkg::A_NMT:
               bresp_ff <= cof_pkg::RESP_OK;
            default: bresp_ff <= cof_pkg::RESP_ERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Configuration registers; only byte lanes below a field's top are used
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_ff <= cof_pkg::CTRL_RST;
         node_ff <= cof_pkg::NODE_RST;
         gain_ff <= cof_pkg::GAIN_RST;
         map_ff <= '{cof_pkg::MAP_RST, cof_pkg::MAP_RST};
      end else if (wr_do) begin
         case (awaddr_ff)
            cof_pkg::A_CTRL: if (wstrb_ff[0]) ctrl_ff <= wdata_ff[3:0];
            cof_pkg::A_NODE: if (wstrb_ff[0]) node_ff <= wdata_ff[6:0];
            cof_pkg::A_GAIN: begin // [R2]
               if (wstrb_ff[0]) gain_ff[7:0] <= wdata_ff[7:0];
               if (wstrb_ff[1]) gain_ff[15:8] <= wdata_ff[15:8];
            end
            cof_pkg::A_MAP1, cof_pkg::A_MAP2: begin // [R6]
               if (wstrb_ff[0]) map_ff[awaddr_ff[4]][7:0] <= wdata_ff[7:0];
               if (wstrb_ff[1]) map_ff[awaddr_ff[4]][15:8] <= wdata_ff[15:8];
               if (wstrb_ff[2]) map_ff[awaddr_ff[4]][18:16] <= wdata_ff[18:16];
            end
            default: ;
         endcase
      end
   end
   assign nmt_wr = wr_do && awaddr_ff == cof_pkg::A_NMT && wstrb_ff[0];
   assign nmt_cmd = wdata_ff[1:0];

   // Read data; reserved bits read as zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {rvalid_ff, rdata_ff, rresp_ff} <= 35'h0;
      end else begin
         rvalid_ff <= nxt_rvalid;
         if (rd_take) begin
            rresp_ff <= cof_pkg::RESP_OK;
            case (s_axi_araddr)
               cof_pkg::A_CTRL: rdata_ff <= {28'h0, ctrl_ff};
               cof_pkg::A_NODE: rdata_ff <= {25'h0, node_ff};
               cof_pkg::A_GAIN: rdata_ff <= {16'h0, gain_ff};
               cof_pkg::A_MAP1: rdata_ff <= {13'h0, map_ff[0]};
               cof_pkg::A_MAP2: rdata_ff <= {13'h0, map_ff[1]};
               cof_pkg::A_NMT: rdata_ff <= {30'h0, nmt_ff};
               cof_pkg::A_STAT: rdata_ff <= {7'h00, tx_valid,
                  mfr_prev_ff, err_reg_ff, 6'h00, boot_ff};
               cof_pkg::A_HIST: rdata_ff <= {8'h00, hist_cnt_ff,
                  hist_code_ff}; // [R12]
               default: begin
                  rdata_ff <= 32'h0;
                  rresp_ff <= cof_pkg::RESP_ERR;
               end
            endcase
         end
      end
   end

   // Boot sequence: init wait, then boot-up and start-up emergency
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         boot_ff <= cof_pkg::BS_INIT;
         init_cnt_ff <= 8'h00;
         node_act_ff <= cof_pkg::NODE_RST;
      end else if (nmt_wr && nmt_cmd == cof_pkg::NMT_INIT) begin
         boot_ff <= cof_pkg::BS_INIT; // Re-initialisation on command
         init_cnt_ff <= 8'h00;
      end else begin
         case (boot_ff)
            cof_pkg::BS_INIT: begin
               init_cnt_ff <= init_cnt_ff + 8'h01;
               if (init_cnt_ff == 8'(cof_pkg::INIT_CYC - 1)) begin
                  node_act_ff <= node_ff; // [R7]
                  boot_ff <= cof_pkg::BS_WAIT;
               end
            end
            cof_pkg::BS_WAIT:
               if (!pend_hb_ff && !pend_e0_ff) boot_ff <= cof_pkg::BS_RUN;
            cof_pkg::BS_RUN: ;
            default: boot_ff <= cof_pkg::BS_INIT;
         endcase
      end
   end

   // Network state: boot, software command and error behaviour
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nmt_ff <= cof_pkg::NMT_INIT; // [R7]
      end else if (boot_ff == cof_pkg::BS_INIT) begin
         nmt_ff <= cof_pkg::NMT_INIT;
      end else if (boot_ff == cof_pkg::BS_WAIT) begin
         if (!pend_hb_ff && !pend_e0_ff) begin
            nmt_ff <= ctrl_ff[cof_pkg::C_PREOP] ? cof_pkg::NMT_PREOP
                                                : cof_pkg::NMT_OP; // [R10]
         end
      end else if (err_evt &&
                   ctrl_ff[cof_pkg::C_EBEH+:2] != cof_pkg::EB_KEEP) begin
         // Error wins over an NMT_PREOP, NMT_OP or NMT_STOP command in the same cycle
         nmt_ff <= ctrl_ff[cof_pkg::C_EBEH+:2] == cof_pkg::EB_STOP ?
                   cof_pkg::NMT_STOP : cof_pkg::NMT_PREOP; // [R13]
      end else if (nmt_wr && nmt_cmd != cof_pkg::NMT_INIT) begin
         nmt_ff <= cof_pkg::cof_nmt_t'(nmt_cmd); // All four codes are states
      end
   end

   // Error register byte from the emergency code class
   function automatic logic [7:0] cof_er(input logic [15:0] c);
      if (c[15:12] == cof_pkg::EC_VOLT[15:12]) cof_er = cof_pkg::ER_VOLT;
      else if (c == cof_pkg::EC_NVM) cof_er = cof_pkg::ER_MFR;
      else cof_er = cof_pkg::ER_GEN; // [R16] [R17]
   endfunction : cof_er

   assign mfr_chg = mfr_status != mfr_prev_ff;

   // Error state, history and manufacturer status tracking
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         err_reg_ff <= cof_pkg::ER_NONE;
         err_code_ff <= cof_pkg::EC_NONE;
         hist_code_ff <= cof_pkg::EC_NONE;
         {mfr_prev_ff, hist_cnt_ff} <= 16'h0000;
      end else begin
         mfr_prev_ff <= mfr_status;
         if (err_evt) begin
            err_code_ff <= err_code;
            err_reg_ff <= cof_er(err_code); // [R16]
            hist_code_ff <= err_code; // [R12]
            if (hist_cnt_ff != 8'hFF) hist_cnt_ff <= hist_cnt_ff + 8'h01;
         end else if (mfr_chg && mfr_status != 8'h00) begin
            err_reg_ff <= cof_pkg::ER_MFR; // [R16]
            hist_code_ff <= cof_pkg::EC_MFR; // [R12]
            if (hist_cnt_ff != 8'hFF) hist_cnt_ff <= hist_cnt_ff + 8'h01;
         end else if (err_clr) begin
            err_reg_ff <= cof_pkg::ER_NONE; // [R20]
            err_code_ff <= cof_pkg::EC_NONE;
         end
      end
   end

   // Pending frames: a new request wins over the take in that cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {pend_hb_ff, pend_e0_ff, pend_err_ff, pend_mfr_ff,
          pend_clr_ff} <= 5'h00;
         pend_p_ff <= '{1'b0, 1'b0};
      end else begin
         pend_hb_ff <= (pend_hb_ff & ~tk_hb) | (boot_ff == cof_pkg::BS_INIT
            && init_cnt_ff == 8'(cof_pkg::INIT_CYC - 1)); // [R8]
         pend_e0_ff <= (pend_e0_ff & ~tk_e0) | (boot_ff == cof_pkg::BS_INIT
            && init_cnt_ff == 8'(cof_pkg::INIT_CYC - 1)); // [R18]
         pend_err_ff <= (pend_err_ff & ~tk_err) | err_evt; // [R9] [R11]
         pend_mfr_ff <= (pend_mfr_ff & ~tk_mfr) | mfr_chg; // [R19]
         pend_clr_ff <= (pend_clr_ff & ~tk_clr) | err_clr; // [R20]
         pend_p_ff[0] <= (pend_p_ff[0] & ~tk_p[0]) |
                         (sample_stb && nmt_ff == cof_pkg::NMT_OP);
         pend_p_ff[1] <= (pend_p_ff[1] & ~tk_p[1]) |
                         (sample_stb && nmt_ff == cof_pkg::NMT_OP &&
                          map_ff[1][cof_pkg::MAP_LEN+:3] != 3'h0);
      end
   end

   // Inclination scaled by the resolution gain, kept signed
   assign gain_s = {1'b0, gain_ff};
   assign prod_x = incl_x * gain_s; // [R1] [R2] [R21]
   assign prod_y = incl_y * gain_s;
   assign srcv[0] = prod_x[cof_pkg::GAIN_SH+:16];
   assign srcv[1] = prod_y[cof_pkg::GAIN_SH+:16];
   assign srcv[2] = temp_c;
   assign srcv[3] = acc_raw_x; // [R5]
   assign srcv[4] = acc_raw_y;
   assign srcv[5] = acc_raw_z;
   assign srcv[6] = acc_cmp_x; // [R5]
   assign srcv[7] = acc_cmp_y;
   assign srcv[8] = acc_cmp_z;

   // Slot count: a zero length in the first map selects the default inclination layout
   assign n_slot[0] = map_ff[0][cof_pkg::MAP_LEN+:3] == 3'h0 ?
      (ctrl_ff[cof_pkg::C_TWOAX] ? 3'h2 : 3'h1) : // [R3] [R4]
      (map_ff[0][cof_pkg::MAP_LEN+:3] > 3'h4 ? 3'h4
                                              : map_ff[0][cof_pkg::MAP_LEN+:3]);
   assign n_slot[1] = map_ff[1][cof_pkg::MAP_LEN+:3] > 3'h4 ? 3'h4
                                              : map_ff[1][cof_pkg::MAP_LEN+:3];

   // Each slot takes its mapped source, low byte first
   for (genvar p = 0; p < 2; p++) begin : g_pdo
      for (genvar i = 0; i < 4; i++) begin : g_slot
         logic [3:0] sel;
         always_comb begin
            sel = map_ff[p][4*i+:4];
            if (p == 0 && map_ff[0][cof_pkg::MAP_LEN+:3] == 3'h0)
               sel = 4'(i); // Default: X then Y
            if (3'(i) >= n_slot[p] || sel > 4'h8) slot_v[p][i] = 16'h0;
            else slot_v[p][i] = srcv[sel]; // [R6]
         end
         assign pdo_data[p][16*i+:16] = slot_v[p][i]; // [R3] [R4]
      end
   end

   // Next frame by priority; boot frames first, process data last
   always_comb begin
      ld = ~tx_valid | tx_ready;
      {tk_hb, tk_e0, tk_err, tk_mfr, tk_clr} = 5'h00;
      tk_p = '{1'b0, 1'b0};
      nxt_valid = 1'b1;
      nxt_id = cof_pkg::ID_EMCY + 11'(node_act_ff);
      nxt_dlc = 4'h8;
      nxt_data = 64'h0;
      if (pend_hb_ff) begin
         tk_hb = ld;
         nxt_id = cof_pkg::ID_HB + 11'(node_act_ff); // [R8]
         nxt_dlc = 4'h1;
         nxt_data = {56'h0, cof_pkg::BOOT_BYTE};
      end else if (pend_e0_ff) begin
         tk_e0 = ld;
         nxt_data = {40'h0, cof_pkg::ER_NONE,
                     cof_pkg::EC_NONE}; // [R18]
      end else if (pend_err_ff) begin
         tk_err = ld;
         nxt_data = {32'h0, mfr_prev_ff, err_reg_ff,
                     err_code_ff}; // [R11] [R14] [R15]
      end else if (pend_mfr_ff) begin
         tk_mfr = ld;
         nxt_data = {32'h0, mfr_prev_ff, err_reg_ff,
                     cof_pkg::EC_MFR}; // [R19] [R14] [R15]
      end else if (pend_clr_ff) begin
         tk_clr = ld; // [R20]
      end else if (pend_p_ff[0]) begin
         tk_p[0] = ld;
         nxt_id = cof_pkg::ID_TPDO1 + 11'(node_act_ff);
         nxt_dlc = {n_slot[0], 1'b0};
         nxt_data = pdo_data[0];
      end else if (pend_p_ff[1]) begin
         tk_p[1] = ld;
         nxt_id = cof_pkg::ID_TPDO2 + 11'(node_act_ff);
         nxt_dlc = {n_slot[1], 1'b0};
         nxt_data = pdo_data[1];
      end else begin
         nxt_valid = 1'b0;
      end
   end

   // Frame register; held stable until the controller takes it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {tx_valid, tx_id, tx_dlc, tx_data} <= 80'h0;
      end else if (ld) begin
         tx_valid <= nxt_valid;
         tx_id <= nxt_id;
         tx_dlc <= nxt_dlc;
         tx_data <= nxt_data;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign nmt_state = nmt_ff;
endmodule : cof_framer

// ---- verilog/cof_pkg.sv ----
// Constants of the process-data and emergency framer: register map,
// field layout, reset values, frame identifiers, codes and timing.
// Assumes a 10 MHz system clock and a CAN controller that takes frames.
// Summary of operation
// [R1] Factory scaling reports hundredths of a degree
// [R2] Resolution register rescales inclination output
// [R3] Single axis: two bytes, low byte first
// [R4] Two axis: X then Y, low first
// [R5] Raw 1 mg and compensated 0.1 mg acceleration
// [R6] Mapping registers choose both process-data payloads
// [R7] Initialisation loads stored parameters at power-on
// [R8] Boot-up sends one zero byte on 700h+node
// [R9] Boot-time error sends emergency with error details
// [R10] After boot, operational or pre-operational by setting
// [R11] Internal error sends eight bytes on 80h+node
// [R12] Each emergency code goes to error history; only error-event codes and 8000h for a nonzero status are stored
// [R13] Error switches network state per error behaviour
// [R14] Bytes 0-1 code, byte 2 error register
// [R15] Bytes 3-7 manufacturer status, zero means none
// [R16] Error register: 00, 01, 05 or 81
// [R17] Fixed emergency code set per error kind
// [R18] Code 0000h emergency always sent at start-up
// [R19] Code 8000h sent on manufacturer status change
// [R20] All errors cleared: all-zero emergency frame
// [R21] Values are signed two's-complement integers
package cof_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_NODE = 8'h04;
   localparam logic [7:0] A_GAIN = 8'h08;
   localparam logic [7:0] A_MAP1 = 8'h0C;
   localparam logic [7:0] A_MAP2 = 8'h10;
   localparam logic [7:0] A_NMT = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_HIST = 8'h1C;
   // Control fields and reset values
   localparam int C_PREOP = 0;
   localparam int C_TWOAX = 1;
   localparam int C_EBEH = 2;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [6:0] NODE_RST = 7'h01;
   localparam logic [15:0] GAIN_RST = 16'h0100;
   localparam int GAIN_SH = 8;
   localparam int MAP_LEN = 16;
   localparam logic [18:0] MAP_RST = 19'h0;
   // Frame identifier bases and boot-up content
   localparam logic [10:0] ID_EMCY = 11'h080;
   localparam logic [10:0] ID_TPDO1 = 11'h180;
   localparam logic [10:0] ID_TPDO2 = 11'h280;
   localparam logic [10:0] ID_HB = 11'h700;
   localparam logic [7:0] BOOT_BYTE = 8'h00;
   // Emergency codes
   localparam logic [15:0] EC_NONE = 16'h0000;
   localparam logic [15:0] EC_GEN = 16'h1000;
   localparam logic [15:0] EC_VOLT = 16'h5000;
   localparam logic [15:0] EC_SELF = 16'h5010;
   localparam logic [15:0] EC_SINIT = 16'h5030;
   localparam logic [15:0] EC_WDOG = 16'h6000;
   localparam logic [15:0] EC_SW = 16'h6200;
   localparam logic [15:0] EC_MFR = 16'h8000;
   localparam logic [15:0] EC_NVM = 16'hFF20;
   // Error register values and manufacturer status bits
   localparam logic [7:0] ER_NONE = 8'h00;
   localparam logic [7:0] ER_GEN = 8'h01;
   localparam logic [7:0] ER_VOLT = 8'h05;
   localparam logic [7:0] ER_MFR = 8'h81;
   localparam logic [7:0] MS_XTILT = 8'h01;
   localparam logic [7:0] MS_YTILT = 8'h02;
   localparam logic [7:0] MS_NVM = 8'h08;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int INIT_NS = 10_000;
   localparam int INIT_CYC = (INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Bus responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // Network and error behaviour states
   typedef enum logic [1:0] {
      NMT_INIT = 2'b00,
      NMT_PREOP = 2'b01,
      NMT_OP = 2'b10,
      NMT_STOP = 2'b11
   } cof_nmt_t;
   localparam logic [1:0] EB_PREOP = 2'h0;
   localparam logic [1:0] EB_KEEP = 2'h1;
   localparam logic [1:0] EB_STOP = 2'h2;
   typedef enum logic [1:0] {
      BS_INIT = 2'b00,
      BS_WAIT = 2'b01,
      BS_RUN = 2'b10
   } cof_boot_t;
endpackage : cof_pkg
